// >>> hdl/wcf_host.sv
// Controller that frames write bursts with an appended 8-bit check value.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
// How it works
// R1 - Check value uses generator polynomial x^8 + x^2 + x + 1.
// R2 - Check value is one combinational 8-bit result over a 72-bit word.
// R3 - Equals serial shifting from zero, bit 71 first, bit 0 last.
// R4 - Each check bit is the XOR of a fixed subset of inputs.
// R5 - Device flags single, double and odd-count bit errors.
// R6 - Device flags errors in one vertical column, inversion bits excepted.
// R7 - In full bursts with checking, writes start at column bits 0:0:0.
// R8 - Lane n, transfer k carries bit 8n+k, then transfers 8 and 9.
// R9 - Four-bit lanes: check bit n in transfer 8, n+4 in transfer 9.
// R10 - Byte lanes: check bit n then a one; mask lane bits 64-71 then ones.
// R11 - Sixteen-bit width has two trees over bits 71..0 and 143..72.
// R12 - Upper lanes carry check bits 8-15 then ones; upper mask 136-143.
// R13 - Chop four is fixed, and A2 picks which data half goes first.
// R14 - Chop four: 16 data inputs, ones in 4-7, check bits in 8-9.
// R15 - Chop four, A2 zero: lane n carries bits 8n to 8n+3 first.
// R16 - A2 one: upper nibbles are sent and fed at lower nibble positions.
// R17 - Device recomputes, compares and raises alert on a mismatch.
// R18 - Device with masking discards a burst whose check mismatches.
// R19 - Device checks bits as received, before undoing inversion.
// R20 - Device compares once per burst after all ten transfers.
module wcf_host (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Software register port.
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Write burst toward the memory device.
   output logic             burst_start,
   output logic      [2:0]  burst_col,
   output logic             burst_chop,
   output logic             burst_select_per_command,
   output logic             beat_valid,
   output logic      [3:0]  beat_index,
   output logic      [15:0] dq_o,
   output logic      [15:0] dq_oe,
   output logic      [1:0]  dmdbi_o,
   output logic      [1:0]  dmdbi_oe
);

   // ****************************************************************
   // Functions.
   // ****************************************************************

   // Bit-serial shift from zero, unrolled into one combinational tree.
   function automatic logic [7:0] crc_next_over_word(
      input logic [71:0] word
   );
      logic [7:0] crc_result_bits;
      logic       fb;
      crc_result_bits = 8'h00; // R3
      for (int i = wcf_pkg::WORD_BITS - 1; i >= 0; i--) begin // R2 R3
         fb = crc_result_bits[7] ^ word[i];
         crc_result_bits = {crc_result_bits[6:0], 1'b0}; // R1 R4
         if (fb) begin
            crc_result_bits = crc_result_bits ^ wcf_pkg::CRC_POLY; // R1
         end
      end
      return crc_result_bits;
   endfunction

   // Builds one 72-bit tree input from 64 data bits and 8 mask bits.
   function automatic logic [71:0] tree_word(
      input logic [63:0] data,
      input logic [7:0]  mask,
      input logic [1:0]  width,
      input logic        chop,
      input logic        a2,
      input logic        mask_used
   );
      logic [71:0] w;
      int          lane;
      int          j;
      int          src;
      w = '1;
      for (int i = 0; i < wcf_pkg::WORD_BITS; i++) begin
         lane = i / wcf_pkg::LANE_BEATS;
         j    = i % wcf_pkg::LANE_BEATS;
         src  = i;
         if (chop && a2) begin
            src = i + wcf_pkg::NIBBLE; // R16
         end
         if (chop && j >= wcf_pkg::NIBBLE) begin
            w[i] = 1'b1; // R14
         end else if (width == wcf_pkg::WCF_X4 && lane > 3) begin
            w[i] = 1'b1; // R14
         end else if (lane == 8) begin
            w[i] = mask_used ? mask[src - 64] : 1'b1; // R10 R12
         end else begin
            w[i] = data[src]; // R8 R15
         end
      end
      return w;
   endfunction

   // ****************************************************************
   // Registers.
   // ****************************************************************
   logic [4:0]        cfg_q;
   logic [127:0]      data_q;
   logic [15:0]       mask_q;
   logic              done_q;
   logic [31:0]       rdata_q;
   wcf_pkg::wcf_state_t state_q;
   logic [3:0]        beat_q;
   logic [71:0]       word_lo_q;
   logic [71:0]       word_hi_q;
   logic [7:0]        crc_lo_q;
   logic [7:0]        crc_hi_q;
   logic [1:0]        width_q;
   logic              chop_q;
   logic              a2_q;
   logic              start_q;
   logic              valid_q;
   logic [3:0]        index_q;
   logic [15:0]       dq_q;
   logic [15:0]       dq_oe_q;
   logic [1:0]        dm_q;
   logic [1:0]        dm_oe_q;

   logic              start_req;
   logic              done_clr;
   logic              last_beat;
   logic [1:0]        cfg_width;
   logic [71:0]       build_lo;
   logic [71:0]       build_hi;
   logic [15:0]       beat_dq;
   logic [1:0]        beat_dm;

   assign cfg_width = cfg_q[wcf_pkg::CFG_WIDTH_LSB +: 2];
   assign start_req = reg_wr && reg_addr == wcf_pkg::OFF_CTRL &&
                      reg_wdata[wcf_pkg::CTRL_START_BIT] &&
                      state_q == wcf_pkg::WCF_IDLE;
   assign done_clr  = reg_wr && reg_addr == wcf_pkg::OFF_CTRL &&
                      reg_wdata[wcf_pkg::CTRL_DONE_BIT];
   assign last_beat = state_q == wcf_pkg::WCF_SEND &&
                      beat_q == wcf_pkg::LAST_BEAT;

   // ****************************************************************
   // Software writes.
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_q  <= wcf_pkg::CFG_RESET;
         data_q <= '0;
         mask_q <= '0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            wcf_pkg::OFF_CFG:   cfg_q           <= reg_wdata[4:0];
            wcf_pkg::OFF_DATA0: data_q[31:0]    <= reg_wdata;
            wcf_pkg::OFF_DATA1: data_q[63:32]   <= reg_wdata;
            wcf_pkg::OFF_DATA2: data_q[95:64]   <= reg_wdata;
            wcf_pkg::OFF_DATA3: data_q[127:96]  <= reg_wdata;
            wcf_pkg::OFF_MASK:  mask_q          <= reg_wdata[15:0];
            default: begin
            end
         endcase
      end
   end

   // A burst that ends in the cycle of a clear still leaves done set.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         done_q <= 1'b0;
      end else if (last_beat) begin
         done_q <= 1'b1;
      end else if (done_clr) begin
         done_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Software reads, answered in the following cycle.
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            wcf_pkg::OFF_CTRL:  rdata_q <= {30'h0, done_q,
                                            state_q == wcf_pkg::WCF_SEND};
            wcf_pkg::OFF_CFG:   rdata_q <= {27'h0, cfg_q};
            wcf_pkg::OFF_DATA0: rdata_q <= data_q[31:0];
            wcf_pkg::OFF_DATA1: rdata_q <= data_q[63:32];
            wcf_pkg::OFF_DATA2: rdata_q <= data_q[95:64];
            wcf_pkg::OFF_DATA3: rdata_q <= data_q[127:96];
            wcf_pkg::OFF_MASK:  rdata_q <= {16'h0, mask_q};
            wcf_pkg::OFF_CRC:   rdata_q <= {16'h0, crc_hi_q, crc_lo_q};
            default:            rdata_q <= 32'h0;
         endcase
      end else begin
         rdata_q <= 32'h0;
      end
   end

   assign reg_rdata = rdata_q;

   // ****************************************************************
   // Frame capture: tree words and check values fixed at start.
   // ****************************************************************
   assign build_lo = tree_word(data_q[63:0], mask_q[7:0], cfg_width,
                               cfg_q[wcf_pkg::CFG_BC4_BIT],
                               cfg_q[wcf_pkg::CFG_A2_BIT],
                               cfg_q[wcf_pkg::CFG_MASK_BIT]);
   assign build_hi = tree_word(data_q[127:64], mask_q[15:8], cfg_width,
                               cfg_q[wcf_pkg::CFG_BC4_BIT],
                               cfg_q[wcf_pkg::CFG_A2_BIT],
                               cfg_q[wcf_pkg::CFG_MASK_BIT]);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         word_lo_q <= '1;
         word_hi_q <= '1;
         crc_lo_q  <= 8'h00;
         crc_hi_q  <= 8'h00;
         width_q   <= 2'b00;
         chop_q    <= 1'b0;
         a2_q      <= 1'b0;
      end else if (start_req) begin
         word_lo_q <= build_lo;
         word_hi_q <= build_hi;
         crc_lo_q  <= crc_next_over_word(build_lo); // R2
         crc_hi_q  <= crc_next_over_word(build_hi); // R11
         width_q   <= cfg_width;
         chop_q    <= cfg_q[wcf_pkg::CFG_BC4_BIT];
         a2_q      <= cfg_q[wcf_pkg::CFG_A2_BIT];
      end
   end

   // ****************************************************************
   // Burst sequencer: ten transfers per burst.
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= wcf_pkg::WCF_IDLE;
         beat_q  <= 4'h0;
      end else begin
         unique case (state_q)
            wcf_pkg::WCF_IDLE: begin
               beat_q <= 4'h0;
               if (start_req) begin
                  state_q <= wcf_pkg::WCF_SEND;
               end
            end
            wcf_pkg::WCF_SEND: begin
               beat_q <= beat_q + 4'h1; // R8
               if (beat_q == wcf_pkg::LAST_BEAT) begin
                  state_q <= wcf_pkg::WCF_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Lane contents for the current transfer.
   // ****************************************************************
   always_comb begin
      beat_dq = 16'hFFFF;
      beat_dm = 2'b11;
      for (int n = 0; n < 8; n++) begin
         if (beat_q < wcf_pkg::CRC_BEAT_LO) begin
            beat_dq[n]     = word_lo_q[8 * n + int'(beat_q[2:0])]; // R8
            beat_dq[n + 8] = word_hi_q[8 * n + int'(beat_q[2:0])]; // R12
         end else if (beat_q == wcf_pkg::CRC_BEAT_LO) begin
            beat_dq[n]     = crc_lo_q[n]; // R9 R10
            beat_dq[n + 8] = crc_hi_q[n]; // R12
         end else if (width_q == wcf_pkg::WCF_X4 && n < 4) begin
            beat_dq[n]     = crc_lo_q[n + 4]; // R9
         end
      end
      if (beat_q < wcf_pkg::CRC_BEAT_LO) begin
         beat_dm[0] = word_lo_q[64 + int'(beat_q[2:0])]; // R10
         beat_dm[1] = word_hi_q[64 + int'(beat_q[2:0])]; // R12
      end
   end

   // ****************************************************************
   // Registered pin outputs.
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         start_q <= 1'b0;
         valid_q <= 1'b0;
         index_q <= 4'h0;
         dq_q    <= 16'hFFFF;
         dq_oe_q <= 16'h0000;
         dm_q    <= 2'b11;
         dm_oe_q <= 2'b00;
      end else begin
         start_q <= state_q == wcf_pkg::WCF_SEND && beat_q == 4'h0;
         valid_q <= state_q == wcf_pkg::WCF_SEND;
         index_q <= beat_q;
         // Idle lanes rest at ones so that stale data never stands there.
         if (state_q == wcf_pkg::WCF_SEND) begin
            dq_q <= beat_dq;
            dm_q <= beat_dm;
         end else begin
            dq_q <= 16'hFFFF;
            dm_q <= 2'b11;
         end
         if (state_q == wcf_pkg::WCF_SEND) begin
            unique case (width_q)
               wcf_pkg::WCF_X4: begin
                  dq_oe_q <= 16'h000F;
                  dm_oe_q <= 2'b00;
               end
               wcf_pkg::WCF_X8: begin
                  dq_oe_q <= 16'h00FF;
                  dm_oe_q <= 2'b01;
               end
               default: begin
                  dq_oe_q <= 16'hFFFF;
                  dm_oe_q <= 2'b11;
               end
            endcase
         end else begin
            dq_oe_q <= 16'h0000;
            dm_oe_q <= 2'b00;
         end
      end
   end

   // Full bursts start at column 0:0:0; a chop puts A2 up front.
   assign burst_col  = {chop_q & a2_q, 2'b00}; // R7 R13
   assign burst_chop = chop_q; // R13
   assign burst_select_per_command = 1'b0; // R13
   assign burst_start = start_q;
   assign beat_valid  = valid_q;
   assign beat_index  = index_q;
   assign dq_o        = dq_q;
   assign dq_oe       = dq_oe_q;
   assign dmdbi_o     = dm_q;
   assign dmdbi_oe    = dm_oe_q;

endmodule

// >>> pkg/wcf_pkg.sv
// Constants and types shared by the write CRC frame controller.
package wcf_pkg;

   // ****************************************************************
   // Register map of the software port (byte addresses).
   // ****************************************************************
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_CFG    = 8'h04;
   localparam logic [7:0] OFF_DATA0  = 8'h08;
   localparam logic [7:0] OFF_DATA1  = 8'h0C;
   localparam logic [7:0] OFF_DATA2  = 8'h10;
   localparam logic [7:0] OFF_DATA3  = 8'h14;
   localparam logic [7:0] OFF_MASK   = 8'h18;
   localparam logic [7:0] OFF_CRC    = 8'h1C;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_DONE_BIT  = 1;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DONE_BIT  = 1;
   localparam int CFG_WIDTH_LSB  = 0;
   localparam int CFG_BC4_BIT    = 2;
   localparam int CFG_A2_BIT     = 3;
   localparam int CFG_MASK_BIT   = 4;

   // ****************************************************************
   // Values after reset and frame figures.
   // ****************************************************************
   localparam logic [4:0] CFG_RESET   = 5'h00;
   localparam logic [7:0] CRC_POLY    = 8'h07;
   localparam int         WORD_BITS   = 72;
   localparam int         LANE_BEATS  = 8;
   localparam logic [3:0] LAST_BEAT   = 4'h9;
   localparam logic [3:0] CRC_BEAT_LO = 4'h8;
   localparam logic [3:0] CRC_BEAT_HI = 4'h9;
   localparam int         NIBBLE      = 4;

   // ****************************************************************
   // Types.
   // ****************************************************************
   typedef enum logic [1:0] {
      WCF_X4  = 2'b00,
      WCF_X8  = 2'b01,
      WCF_X16 = 2'b10
   } wcf_width_t;

   typedef enum logic {
      WCF_IDLE = 1'b0,
      WCF_SEND = 1'b1
   } wcf_state_t;

endpackage

// >>> verification/wcf_props.sv
// Port-level checks on the write CRC frame controller.
`timescale 1ns/1ps
module wcf_props (
   // Clock, reset and software port.
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Burst toward the memory device.
   input wire logic        burst_start,
   input wire logic [2:0]  burst_col,
   input wire logic        burst_chop,
   input wire logic        burst_select_per_command,
   input wire logic        beat_valid,
   input wire logic [3:0]  beat_index,
   input wire logic [15:0] dq_o,
   input wire logic [15:0] dq_oe,
   input wire logic [1:0]  dmdbi_o,
   input wire logic [1:0]  dmdbi_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_data8;
      (beat_valid && beat_index < 4'h8)[*8];
   endsequence
   sequence s_check2;
      (beat_valid && beat_index >= 4'h8)[*2];
   endsequence
   property p_frame;
      burst_start |-> s_data8 ##1 s_check2 ##1 !beat_valid;
   endproperty
   property p_step;
      beat_valid && beat_index != 4'h9 |=>
         beat_valid && beat_index == $past(beat_index) + 4'h1;
   endproperty
   property p_col;
      beat_valid && !burst_chop |-> burst_col == 3'h0;
   endproperty
   property p_fixed;
      burst_start |-> !burst_select_per_command && $stable(burst_chop);
   endproperty
   property p_chop;
      beat_valid && burst_chop && beat_index[3:2] == 2'b01 |->
         &(dq_o | ~dq_oe) && &(dmdbi_o | ~dmdbi_oe);
   endproperty
   property p_last;
      beat_valid && beat_index == 4'h9 && dq_oe[4] |->
         dq_o == 16'hFFFF && dmdbi_o == 2'b11;
   endproperty
   property p_mask8;
      beat_valid && beat_index == 4'h8 |-> &(dmdbi_o | ~dmdbi_oe);
   endproperty
   property p_idle;
      !beat_valid |-> dq_oe == 16'h0 && dmdbi_oe == 2'h0 &&
         dq_o == 16'hFFFF && dmdbi_o == 2'b11;
   endproperty
   property p_rdata;
      !reg_rd || reg_addr > 8'h1F |=> reg_rdata == 32'h0;
   endproperty
   a_frame: assert property (p_frame) else $error("burst length wrong");
   a_step: assert property (p_step) else $error("transfer order wrong");
   a_col: assert property (p_col) else $error("start column not zero");
   a_fixed: assert property (p_fixed) else $error("chop not fixed");
   a_chop: assert property (p_chop) else $error("chop tail not ones");
   a_last: assert property (p_last) else $error("last transfer not ones");
   a_mask8: assert property (p_mask8) else $error("mask lane crc slot");
   a_idle: assert property (p_idle) else $error("lanes driven while idle");
   a_rdata: assert property (p_rdata) else $error("stray read data");
endmodule
bind wcf_host wcf_props u_props (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .burst_start(burst_start),
   .burst_col(burst_col), .burst_chop(burst_chop),
   .burst_select_per_command(burst_select_per_command),
   .beat_valid(beat_valid), .beat_index(beat_index), .dq_o(dq_o),
   .dq_oe(dq_oe), .dmdbi_o(dmdbi_o), .dmdbi_oe(dmdbi_oe));

// >>> verification/wcf_dev_model.sv
// Memory device model that captures write bursts and checks their CRC.
`timescale 1ns/1ps
module wcf_dev_model (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Burst from the controller.
   input  wire logic        beat_valid,
   input  wire logic [3:0]  beat_index,
   input  wire logic [15:0] dq_o,
   input  wire logic [15:0] dq_oe,
   input  wire logic [1:0]  dmdbi_o,
   input  wire logic [1:0]  dmdbi_oe,
   // Captured frame and check result.
   output logic      [71:0] rx_lo,
   output logic      [71:0] rx_hi,
   output logic      [15:0] rx_crc,
   output logic      [1:0]  crc_err,
   output logic             frame_done,
   output logic             rx_kept
);
   logic [15:0] ln;
   logic [1:0]  mk;
   logic        fin_q;
   logic        wide_q;
   function automatic logic [7:0] crc8(input logic [71:0] w);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 71; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   // Undriven lanes are terminated high, so they read as ones.
   assign ln = dq_o | ~dq_oe;
   assign mk = dmdbi_o | ~dmdbi_oe;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_lo <= 72'h0;
         rx_hi <= 72'h0;
         rx_crc <= 16'h0;
         crc_err <= 2'b00;
         frame_done <= 1'b0;
         rx_kept <= 1'b0;
         fin_q <= 1'b0;
         wide_q <= 1'b0;
      end else begin
         fin_q <= 1'b0;
         frame_done <= fin_q;
         if (fin_q) begin
            crc_err[0] <= crc8(rx_lo) != rx_crc[7:0];
            crc_err[1] <= wide_q && crc8(rx_hi) != rx_crc[15:8];
            // A frame whose check mismatches clears rx_kept; rx_lo and rx_hi still hold it.
            rx_kept <= crc8(rx_lo) == rx_crc[7:0] &&
                       (!wide_q || crc8(rx_hi) == rx_crc[15:8]);
         end
         if (beat_valid && beat_index < 4'h8) begin
            for (int n = 0; n < 8; n++) begin
               rx_lo[8*n+beat_index] <= ln[n];
               rx_hi[8*n+beat_index] <= ln[8+n];
            end
            rx_lo[64+beat_index] <= mk[0];
            rx_hi[64+beat_index] <= mk[1];
         end else if (beat_valid && beat_index == 4'h8) begin
            rx_crc <= ln;
            wide_q <= dq_oe[8];
         end else if (beat_valid) begin
            if (!dq_oe[4])
               rx_crc[7:4] <= ln[3:0];
            fin_q <= 1'b1;
         end
      end
   end
endmodule

// >>> verification/wcf_host_tb.sv
// Self-checking bench for the write CRC frame controller.
`timescale 1ns/1ps
module wcf_host_tb;
   localparam logic [4:0] CFGS [7] =
      '{5'h00, 5'h11, 5'h02, 5'h04, 5'h0C, 5'h1E, 5'h15};
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        burst_start, burst_chop, burst_select_per_command;
   logic        beat_valid, frame_done, rx_kept;
   logic [2:0]  burst_col;
   logic [3:0]  beat_index;
   logic [15:0] dq_o, dq_oe, rx_crc;
   logic [1:0]  dmdbi_o, dmdbi_oe, crc_err;
   logic [71:0] rx_lo, rx_hi;
   int          failures = 0;
   int          n_tests = 0;

   always #5 core_clk = ~core_clk;

   wcf_host dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .burst_start(burst_start),
      .burst_col(burst_col), .burst_chop(burst_chop),
      .burst_select_per_command(burst_select_per_command),
      .beat_valid(beat_valid), .beat_index(beat_index), .dq_o(dq_o),
      .dq_oe(dq_oe), .dmdbi_o(dmdbi_o), .dmdbi_oe(dmdbi_oe));
   wcf_dev_model u_dev (.core_clk(core_clk), .rst(rst),
      .beat_valid(beat_valid), .beat_index(beat_index), .dq_o(dq_o),
      .dq_oe(dq_oe), .dmdbi_o(dmdbi_o), .dmdbi_oe(dmdbi_oe),
      .rx_lo(rx_lo), .rx_hi(rx_hi), .rx_crc(rx_crc),
      .crc_err(crc_err), .frame_done(frame_done), .rx_kept(rx_kept));

   // ****************************************************************
   // Bus access, expectations and reporting.
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input string nm, input logic [71:0] e, g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] crc8(input logic [71:0] w);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 71; i >= 0; i--) begin
         fb = c[7] ^ w[i];
         c = fb ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
      return c;
   endfunction
   // Builds the code word one tree sees for a given configuration.
   function automatic logic [71:0] ew(input logic [63:0] d,
                                      input logic [7:0]  m,
                                      input logic [4:0]  cf);
      logic [71:0] w;
      int          s;
      w = '1;
      s = (cf[2] && cf[3]) ? 4 : 0;
      for (int n = 0; n < 9; n++)
         for (int k = 0; k < 8; k++)
            if (!(cf[1:0] == 2'b00 && n > 3) && !(cf[2] && k > 3))
               w[8*n+k] = (n < 8) ? d[8*n+k+s] : (m[k+s] | ~cf[4]);
      return w;
   endfunction

   initial begin
      repeat (3000) @(posedge core_clk);
      failures++;
      conclude();
   end

   initial begin
      logic [31:0]  v;
      logic [127:0] dat;
      logic [15:0]  msk;
      logic [71:0]  e;
      logic [4:0]   cf;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      for (int a = 0; a < 9; a++) begin
         rd(8'(4 * a), v);
         chk("reset_value", 72'h0, v);
      end
      wr(8'h20, 32'hFFFF_FFFF);
      rd(wcf_pkg::OFF_CFG, v);
      chk("unmapped_write", 72'h0, v);
      for (int i = 0; i < 7; i++) begin
         cf = CFGS[i];
         dat = {32'h3C5A_96E1 ^ 32'(i), 32'h0F1E_2D3C,
                32'hA5C3_0F96 + 32'(i), 32'h6B8D_F127};
         msk = 16'h5AC3 ^ 16'(i);
         for (int j = 0; j < 4; j++)
            wr(wcf_pkg::OFF_DATA0 + 8'(4 * j), dat[32*j+:32]);
         wr(wcf_pkg::OFF_MASK, {16'h0, msk});
         wr(wcf_pkg::OFF_CFG, {27'h0, cf});
         rd(wcf_pkg::OFF_CFG, v);
         chk("cfg", {67'h0, cf}, v);
         wr(wcf_pkg::OFF_CTRL, 32'h1);
         wr(wcf_pkg::OFF_CTRL, 32'h1);
         rd(wcf_pkg::OFF_CTRL, v);
         chk("busy", 72'h1, v);
         for (int t = 0; t < 40 && frame_done !== 1'b1; t++)
            @(negedge core_clk);
         chk("frame", 72'h1, frame_done);
         e = ew(dat[63:0], msk[7:0], cf);
         chk("word_lo", e, rx_lo);
         chk("crc_lo", crc8(e), rx_crc[7:0]);
         chk("crc_err", 72'h0, crc_err);
         chk("kept", 72'h1, rx_kept);
         chk("column", {cf[3] & cf[2], 2'b00}, burst_col);
         rd(wcf_pkg::OFF_CRC, v);
         chk("crc_reg", crc8(e), v[7:0]);
         if (cf[1]) begin
            e = ew(dat[127:64], msk[15:8], cf);
            chk("word_hi", e, rx_hi);
            chk("crc_hi", crc8(e), v[15:8]);
            chk("crc_hi_wire", crc8(e), rx_crc[15:8]);
         end
         rd(wcf_pkg::OFF_CTRL, v);
         chk("done", 72'h2, v);
         wr(wcf_pkg::OFF_CTRL, 32'h2);
         rd(wcf_pkg::OFF_CTRL, v);
         chk("done_clear", 72'h0, v);
         chk("no_second_burst", 72'h0, beat_valid);
      end
      conclude();
   end
endmodule
